// *** core/ssp_pkg.sv ***
// Purpose: shared constants and types for the serial unit spi core
// Assumes: 8-bit registers on a 32-bit avalon-mm slave, word aligned
// Notes:   register indices times four give the byte address

package ssp_pkg;

	// ------------------------------------------------------------
	// register indices (byte address = index * 4)
	// ------------------------------------------------------------
	localparam logic [7:0] IDX_OUT_CTRL = 8'h8F;
	localparam logic [7:0] IDX_SPI_CTRL = 8'h9D;
	localparam logic [7:0] IDX_SPI_STAT = 8'h9E;
	localparam logic [7:0] IDX_SPI_DATA = 8'h9F;
	localparam logic [7:0] IDX_EV_STAT = 8'hA0;
	localparam logic [7:0] IDX_EV_EN = 8'hA1;
	localparam logic [7:0] IDX_EV_CLR = 8'hA2;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int OC_PROT_HI = 7;
	localparam int OC_PROT_LO = 6;
	localparam int CT_SPI_ON = 7;
	localparam int CT_ROLE = 5;
	localparam int CT_IDLE_LVL = 4;
	localparam int CT_SAMPLE = 3;
	localparam int ST_DONE = 7;
	localparam int ST_WRITE_COLLISION_FLAG = 6;
	localparam int ST_TXE = 3;
	localparam int ST_ORDER = 2;
	localparam int ST_IRQ_EN = 0;
	localparam int EV_DONE = 0;
	localparam int EV_WRITE_COLLISION_FLAG = 1;
	localparam int EV_TXE = 2;

	// ------------------------------------------------------------
	// encodings, reset values and counts
	// ------------------------------------------------------------
	localparam logic [1:0] PROT_OFF = 2'h0;
	localparam logic [1:0] PROT_SPI = 2'h1;
	localparam logic [1:0] PROT_TWI = 2'h2;
	localparam logic [1:0] PROT_UART = 2'h3;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [2:0] RST_EV = 3'h0;
	localparam logic [8:0] HALF_BASE = 9'h002;
	localparam logic [3:0] LAST_EDGE = 4'hF;
	localparam logic [3:0] FIRST_EDGE_DONE = 4'h1;

	typedef enum logic [1:0]
	{
		SSP_IDLE = 2'b00,
		SSP_RUN = 2'b01,
		SSP_DRAIN = 2'b11
	} ssp_state_e;

endpackage : ssp_pkg

// *** core/ssp_core.sv ***
// Purpose: spi personality of the shared serial unit with its registers
// Assumes: one clock domain; spi pins pass two flops before use
// Notes:   avalon-mm slave with one wait cycle per access
//
// Operation
// - protocol select: off, spi, twi, uart
// - twi personality acts only as slave
// - uart personality: 10 and 11 bit frames
// - control bit 7 enables spi, resets 0
// - control bit 5 selects master or slave
// - control bit 4 sets clock idle level
// - control bit 3 picks first/second sampling edge
// - rate field divides clock /4 to /512
// - done flag set on byte end, sw clears
// - collision flag set on conflicting data write
// - tx empty flag set when buffer empties
// - status bit 2 picks msb/lsb first
// - irq when done flag and enable both set
// - data write loads tx, read gives rx
// - slave sends zero byte when nothing loaded
// - unselected slave floats output, ignores clock
// - slave holds rx until done flag cleared
`timescale 1ns/100ps

module ssp_core
	import ssp_pkg::*;
#(
	parameter int ADDR_W = 10
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	output logic irq,
	output logic twiEnable,
	output logic uartEnable,
	input wire logic sckIn,
	output logic sckOut,
	output logic sckOe,
	input wire logic mosiIn,
	output logic mosiOut,
	output logic mosiOe,
	input wire logic misoIn,
	output logic misoOut,
	output logic misoOe,
	input wire logic slaveSelN
);

	// ------------------------------------------------------------
	// helper functions
	// ------------------------------------------------------------
	// half of the serial clock period in system clocks
	function automatic logic [8:0] halfLimit(input logic [2:0] rate);
		halfLimit = HALF_BASE << rate;
	endfunction : halfLimit

	// one shift step; new bit enters opposite the outgoing end
	function automatic logic [7:0] shiftStep(input logic [7:0] cur, input logic din,
		input logic lsbFirst);
		shiftStep = lsbFirst ? {din, cur[7:1]} : {cur[6:0], din};
	endfunction : shiftStep

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	logic ackQ;
	logic [1:0] protSel;
	logic [3:0] outCtrlLow;
	logic spiOn, roleMaster, clock_idle_level, sample_edge_select;
	logic [2:0] rate;
	logic doneFlag, wcolFlag, txeFlag, lsbFirst, transfer_irq_enable;
	logic [7:0] txBuf, txShift, rxShift, rxData;
	logic txFull;
	logic [3:0] edgeIdx;
	logic [8:0] halfCnt;
	logic sckPhase;
	logic [1:0] captPipe;
	logic [2:0] evStatus, evEnable;
	ssp_state_e state, next_state;
	logic sckMeta, sckSync, sckPrev;
	logic mosiMeta, mosiSync, misoMeta, misoSync, ssMeta, ssSync;

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	// two flops per pin, a third on sck for edge detect; the first stage feeds no logic
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			{sckMeta, sckSync, sckPrev} <= 3'h0;
			{mosiMeta, mosiSync, misoMeta, misoSync} <= 4'h0;
			{ssMeta, ssSync} <= 2'h3;
		end
		else
		begin
			{sckMeta, sckSync, sckPrev} <= {sckIn, sckMeta, sckSync};
			{mosiMeta, mosiSync} <= {mosiIn, mosiMeta};
			{misoMeta, misoSync} <= {misoIn, misoMeta};
			{ssMeta, ssSync} <= {slaveSelN, ssMeta};
		end
	end

	// ------------------------------------------------------------
	// bus decode
	// ------------------------------------------------------------
	// every access waits exactly one cycle, reads and writes alike
	wire busReq = read | write;
	wire [7:0] addrIdx = address[ADDR_W-1:2];
	wire aligned = (address[1:0] == 2'h0);
	wire wrFire = write & ackQ & byteenable[0];
	wire [7:0] wd = writedata[7:0];
	wire wrOutCtrl = wrFire & aligned & (addrIdx == IDX_OUT_CTRL);
	wire wrSpiCtrl = wrFire & aligned & (addrIdx == IDX_SPI_CTRL);
	wire wrSpiStat = wrFire & aligned & (addrIdx == IDX_SPI_STAT);
	wire wrSpiData = wrFire & aligned & (addrIdx == IDX_SPI_DATA);
	wire wrEvEn = wrFire & aligned & (addrIdx == IDX_EV_EN);
	wire wrEvClr = wrFire & aligned & (addrIdx == IDX_EV_CLR);
	assign waitrequest = busReq & ~ackQ;

	// ------------------------------------------------------------
	// mode decode
	// ------------------------------------------------------------
	// protocol select decode
	wire spiMode = (protSel == PROT_SPI);
	// twi slave only; no clock or data drive here
	assign twiEnable = (protSel == PROT_TWI);
	assign uartEnable = (protSel == PROT_UART);
	wire spiActive = spiMode & spiOn;
	// select seen only through the synchroniser
	wire selected = ~ssSync;

	// ------------------------------------------------------------
	// transfer engine control
	// ------------------------------------------------------------
	// divider half period
	wire [8:0] halfLim = halfLimit(rate);
	wire halfTick = (state != SSP_IDLE) & (halfCnt == halfLim - 9'h001);
	wire slaveEdge = sckSync ^ sckPrev;
	// a pending done flag freezes the slave
	wire slaveLive = spiActive & ~roleMaster & selected & ~doneFlag;
	// master starts itself, slave waits for an edge
	wire masterStart = spiActive & roleMaster & (state == SSP_IDLE) & txFull;
	wire slaveStart = slaveLive & (state == SSP_IDLE) & slaveEdge;
	wire startNow = masterStart | slaveStart;
	// leaving spi or deselect aborts the byte
	wire abort = ~spiActive | (~roleMaster & ~selected);
	wire edgeHit = roleMaster ? ((state == SSP_RUN) & halfTick)
		: (slaveLive & slaveEdge & (state != SSP_DRAIN));
	// sample on first or second edge of each bit
	wire sampleEdge = edgeHit & (edgeIdx[0] == sample_edge_select);
	wire shiftEdge = edgeHit & (edgeIdx[0] != sample_edge_select) & ~(sample_edge_select & (edgeIdx == 4'h0));
	wire lastEdge = edgeHit & (edgeIdx == LAST_EDGE);
	// an abort in the drain cycle must not raise the done flag
	wire finish = (state == SSP_DRAIN) & ~abort & (roleMaster ? halfTick : 1'b1);

	// master reads miso two clocks late, the pin settled at its edge
	wire captStrobe = roleMaster ? captPipe[1] : sampleEdge;
	wire dataIn = roleMaster ? misoSync : mosiSync;
	wire [7:0] rxIn = shiftStep(rxShift, dataIn, lsbFirst);
	wire [7:0] next_rxShift = captStrobe ? rxIn : rxShift;
	// idle shifter holds the buffer or a zero byte
	wire [7:0] txLoad = txFull ? txBuf : RST_BYTE;
	wire [7:0] next_txShift = (state == SSP_IDLE) ? txLoad
		: (shiftEdge ? shiftStep(txShift, 1'b0, lsbFirst) : txShift);
	wire next_sckPhase = (state == SSP_IDLE) | abort ? 1'b0 : sckPhase ^ (roleMaster & edgeHit);
	wire [3:0] next_edgeIdx = slaveStart ? FIRST_EDGE_DONE
		: ((state == SSP_IDLE) | abort ? 4'h0 : edgeIdx + {3'h0, edgeHit});
	wire [8:0] next_halfCnt = (state == SSP_IDLE) | halfTick ? 9'h000 : halfCnt + 9'h001;

	// ------------------------------------------------------------
	// flag events
	// ------------------------------------------------------------
	// busy or loaded buffer makes a data write collide
	wire collide = wrSpiData & spiActive & (txFull | (state != SSP_IDLE) | startNow);
	wire txEmptied = startNow & txFull;
	wire [2:0] evSet = {txEmptied, collide, finish};

	// ------------------------------------------------------------
	// state machine
	// ------------------------------------------------------------
	always_comb
	begin
		next_state = state;
		unique case (state)
			SSP_IDLE:
			begin
				if (startNow)
					next_state = SSP_RUN;
			end
			SSP_RUN:
			begin
				if (abort)
					next_state = SSP_IDLE;
				else if (lastEdge)
					next_state = SSP_DRAIN;
			end
			SSP_DRAIN:
			begin
				if (abort | finish)
					next_state = SSP_IDLE;
			end
			default:
			begin
				next_state = SSP_IDLE;
			end
		endcase
	end

	// engine registers
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			state <= SSP_IDLE;
			edgeIdx <= 4'h0;
			halfCnt <= 9'h000;
			sckPhase <= 1'b0;
			captPipe <= 2'h0;
			txShift <= RST_BYTE;
			rxShift <= RST_BYTE;
		end
		else
		begin
			state <= next_state;
			edgeIdx <= next_edgeIdx;
			halfCnt <= next_halfCnt;
			sckPhase <= next_sckPhase;
			captPipe <= {captPipe[0], sampleEdge & roleMaster};
			txShift <= next_txShift;
			rxShift <= next_rxShift;
		end
	end

	// ------------------------------------------------------------
	// pin drivers
	// ------------------------------------------------------------
	// clock rests at the idle level outside a byte
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			sckOut <= 1'b0;
			mosiOut <= 1'b0;
			misoOut <= 1'b0;
		end
		else
		begin
			sckOut <= clock_idle_level ^ next_sckPhase;
			mosiOut <= lsbFirst ? next_txShift[0] : next_txShift[7];
			misoOut <= lsbFirst ? next_txShift[0] : next_txShift[7];
		end
	end

	// only an enabled master drives clock and mosi
	assign sckOe = spiActive & roleMaster;
	assign mosiOe = spiActive & roleMaster;
	assign misoOe = spiActive & ~roleMaster & selected;

	// ------------------------------------------------------------
	// configuration registers
	// ------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			protSel <= PROT_OFF;
			outCtrlLow <= 4'h0;
			{spiOn, roleMaster, clock_idle_level, sample_edge_select} <= 4'h0;
			rate <= 3'h0;
			{lsbFirst, transfer_irq_enable} <= 2'h0;
			evEnable <= RST_EV;
		end
		else
		begin
			if (wrOutCtrl)
			begin
				protSel <= wd[OC_PROT_HI:OC_PROT_LO];
				outCtrlLow <= wd[3:0];
			end
			if (wrSpiCtrl)
			begin
				spiOn <= wd[CT_SPI_ON];
				roleMaster <= wd[CT_ROLE];
				clock_idle_level <= wd[CT_IDLE_LVL];
				sample_edge_select <= wd[CT_SAMPLE];
				rate <= wd[2:0];
			end
			if (wrSpiStat)
			begin
				lsbFirst <= wd[ST_ORDER];
				transfer_irq_enable <= wd[ST_IRQ_EN];
			end
			if (wrEvEn)
				evEnable <= wd[2:0];
		end
	end

	// ------------------------------------------------------------
	// status flags and data path
	// ------------------------------------------------------------
	// a write of 0 clears a flag; a same-cycle hardware set wins
	wire clrDone = wrSpiStat & ~wd[ST_DONE];
	wire clrWcol = wrSpiStat & ~wd[ST_WRITE_COLLISION_FLAG];
	wire clrTxe = wrSpiStat & ~wd[ST_TXE];

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			{doneFlag, wcolFlag, txeFlag} <= 3'h0;
			evStatus <= RST_EV;
		end
		else
		begin
			doneFlag <= finish | (doneFlag & ~clrDone);
			wcolFlag <= collide | (wcolFlag & ~clrWcol);
			txeFlag <= txEmptied | (txeFlag & ~clrTxe);
			evStatus <= evSet | (evStatus & ~(wrEvClr ? wd[2:0] : 3'h0));
		end
	end

	// data write fills the tx buffer, rx latched at byte end
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			txBuf <= RST_BYTE;
			txFull <= 1'b0;
			rxData <= RST_BYTE;
		end
		else
		begin
			if (wrSpiData & ~collide)
				txBuf <= wd;
			// collided writes leave buffer and shifter untouched
			txFull <= (wrSpiData & ~collide) | (txFull & ~startNow);
			// received byte kept until next completed byte
			if (finish)
				rxData <= next_rxShift;
		end
	end

	// ------------------------------------------------------------
	// interrupt
	// ------------------------------------------------------------
	// done flag gated by its enable, plus enabled events
	assign irq = (doneFlag & transfer_irq_enable) | (|(evStatus & evEnable));

	// ------------------------------------------------------------
	// read path
	// ------------------------------------------------------------
	wire [7:0] rdOutCtrl = {protSel, 2'h0, outCtrlLow};
	wire [7:0] rdSpiCtrl = {spiOn, 1'b0, roleMaster, clock_idle_level, sample_edge_select, rate};
	wire [7:0] rdSpiStat = {doneFlag, wcolFlag, 2'h0, txeFlag, lsbFirst, 1'b0, transfer_irq_enable};
	// unmapped and write-only addresses read as zero
	wire [7:0] rdMux = ~aligned ? 8'h00
		: (addrIdx == IDX_OUT_CTRL) ? rdOutCtrl
		: (addrIdx == IDX_SPI_CTRL) ? rdSpiCtrl
		: (addrIdx == IDX_SPI_STAT) ? rdSpiStat
		: (addrIdx == IDX_SPI_DATA) ? rxData
		: (addrIdx == IDX_EV_STAT) ? {5'h00, evStatus}
		: (addrIdx == IDX_EV_EN) ? {5'h00, evEnable}
		: 8'h00;

	// read data captured in the wait cycle, valid when waitrequest drops
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			ackQ <= 1'b0;
			readdata <= 32'h0000_0000;
		end
		else
		begin
			ackQ <= busReq & ~ackQ;
			if (read & ~ackQ)
				readdata <= {24'h00_0000, rdMux};
		end
	end

endmodule : ssp_core

// *** dv/ssp_core_assertions.sv ***
// Purpose: port checks for the spi core
// Assumes: bound to every ssp_core, one clock, sync reset
// Notes:   only design outputs are judged
`timescale 1ns/100ps
module ssp_core_assertions
	import ssp_pkg::*;
#(
	parameter int ADDR_W = 10
)
(
	input logic clk,
	input logic rst,
	input logic [ADDR_W-1:0] address,
	input logic read,
	input logic write,
	input logic [31:0] writedata,
	input logic [3:0] byteenable,
	input logic [31:0] readdata,
	input logic waitrequest,
	input logic irq,
	input logic twiEnable,
	input logic uartEnable,
	input logic sckIn,
	input logic sckOut,
	input logic sckOe,
	input logic mosiIn,
	input logic mosiOut,
	input logic mosiOe,
	input logic misoIn,
	input logic misoOut,
	input logic misoOe,
	input logic slaveSelN
);
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	AST_ONE_MODE: assert property (!(twiEnable && uartEnable))
		else $error("twi and uart on together");
	AST_OTHER_MODE: assert property ((twiEnable || uartEnable) |-> !sckOe && !misoOe)
		else $error("spi pin driven outside spi mode");
	AST_ROLE: assert property (mosiOe == sckOe && !(sckOe && misoOe))
		else $error("master and slave enables disagree");
	// deselected float; four samples cover the sync lag
	AST_DESEL: assert property (slaveSelN [*4] |-> !misoOe)
		else $error("slave output driven while deselected");
	AST_HALF: assert property (sckOe && $changed(sckOut) |=> $stable(sckOut))
		else $error("serial clock half period too short");
	AST_IDLE: assert property (!sckOe && !write && !$past(write) |=> $stable(sckOut))
		else $error("serial clock moved while not master");
	AST_WAIT: assert property ($rose(read || write) |-> waitrequest ##1 !waitrequest)
		else $error("bus answer not after one wait cycle");
	AST_RDHI: assert property (read && !waitrequest |-> readdata[31:8] == 24'h0)
		else $error("read data upper bits set");
	COV_IRQ: cover property ($rose(irq));
	COV_SLAVE: cover property ($rose(misoOe));
	COV_MASTER: cover property (sckOe && $changed(sckOut));
endmodule : ssp_core_assertions

bind ssp_core ssp_core_assertions #(.ADDR_W(ADDR_W)) ssp_core_assertions_i (.clk(clk),
	.rst(rst), .address(address), .read(read), .write(write), .writedata(writedata),
	.byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest), .irq(irq),
	.twiEnable(twiEnable), .uartEnable(uartEnable), .sckIn(sckIn), .sckOut(sckOut),
	.sckOe(sckOe), .mosiIn(mosiIn), .mosiOut(mosiOut), .mosiOe(mosiOe), .misoIn(misoIn),
	.misoOut(misoOut), .misoOe(misoOe), .slaveSelN(slaveSelN));

// *** dv/ssp_spi_peer.sv ***
// Purpose: behavioural spi slave facing the core in master role
// Assumes: always selected; restart pulse opens each frame
// Notes:   data line flips after its hold time so stale bits never pass
`timescale 1ns/100ps
module ssp_spi_peer
(
	input wire logic sck,
	input wire logic mosi,
	input wire logic sample_edge_select,
	input wire logic lsb,
	input wire logic restart,
	input wire logic [7:0] txByte,
	output logic miso,
	output logic [7:0] rxByte
);
	int n = 0;
	function automatic logic pick(int k);
		return lsb ? txByte[k] : txByte[7 - k];
	endfunction : pick
	initial miso = 1'b0;
	initial rxByte = 8'h00;
	// frame start presents the first bit
	always @(posedge restart)
	begin
		n = 0;
		miso = pick(0);
	end
	// edge counting, sample on first or second edge
	always @(sck)
	begin
		n = n + 1;
		if ((n % 2) == (sample_edge_select ? 0 : 1))
			rxByte = lsb ? {mosi, rxByte[7:1]} : {rxByte[6:0], mosi};
		else if (n < 16)
			miso = pick(sample_edge_select ? (n - 1) / 2 : n / 2);
		if (n == 16)
			miso <= #40 !miso;
	end
endmodule : ssp_spi_peer

// *** dv/test_ssp_core.sv ***
// Purpose: register level test of the spi core
// Assumes: peer slave on the pins, bench plays master for slave role
// Notes:   all waits bounded; watchdog ends a hang
`timescale 1ns/100ps
module test_ssp_core
	import ssp_pkg::*;
();
	logic clk, rst, read, write, tSck, tMosi, ssN, restart, peerCpha, peerLsb;
	logic [9:0] address;
	logic [31:0] writedata, readdata, q;
	logic [3:0] byteenable;
	logic waitrequest, irq, twiEnable, uartEnable, sckOut, sckOe, mosiOut, mosiOe;
	logic misoOut, misoOe, peerMiso;
	logic [7:0] peerTx, peerRx, b;
	int errors = 0;
	int comparisons = 0;
	// wire levels from every driver's enable
	wire logic sckW = sckOe ? sckOut : tSck;
	wire logic mosiW = mosiOe ? mosiOut : tMosi;
	wire logic misoW = misoOe ? misoOut : peerMiso;
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	ssp_core ssp_core_i (.clk(clk), .rst(rst), .address(address), .read(read),
		.write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .irq(irq), .twiEnable(twiEnable), .uartEnable(uartEnable),
		.sckIn(sckW), .sckOut(sckOut), .sckOe(sckOe), .mosiIn(mosiW), .mosiOut(mosiOut),
		.mosiOe(mosiOe), .misoIn(misoW), .misoOut(misoOut), .misoOe(misoOe), .slaveSelN(ssN));
	ssp_spi_peer ssp_spi_peer_i (.sck(sckW), .mosi(mosiW), .sample_edge_select(peerCpha), .lsb(peerLsb),
		.restart(restart), .txByte(peerTx), .miso(peerMiso), .rxByte(peerRx));
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task stop_test;
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : stop_test
	task chk(input string n, input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e)
		begin
			errors++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	// one avalon access; request held until waitrequest low
	task bus(input logic w, input logic [7:0] i, input logic [7:0] d, output logic [31:0] r);
		int t;
		t = 0;
		address <= {i, 2'b00};
		writedata <= {24'h0, d};
		read <= !w;
		write <= w;
		do
		begin
			@(posedge clk);
			t++;
		end
		while (waitrequest !== 1'b0 && t < 20);
		r = readdata;
		chk("waitrequest", 32'(waitrequest), 0);
		read <= 1'b0;
		write <= 1'b0;
		@(posedge clk);
	endtask : bus
	task wr(input logic [7:0] i, input logic [7:0] d);
		logic [31:0] x;
		bus(1'b1, i, d, x);
	endtask : wr
	task rd(input logic [7:0] i, output logic [31:0] r);
		bus(1'b0, i, 8'h00, r);
	endtask : rd
	// bench as mode 0 master, 80 ns serial clock
	task slv(input logic sel, input logic [7:0] d, output logic [7:0] got);
		ssN <= !sel;
		repeat (4) @(posedge clk);
		for (int i = 7; i >= 0; i--)
		begin
			tMosi <= d[i];
			repeat (4) @(posedge clk);
			got[i] = misoW;
			tSck <= 1'b1;
			repeat (4) @(posedge clk);
			tSck <= 1'b0;
		end
		repeat (4) @(posedge clk);
		ssN <= 1'b1;
		tMosi <= !d[0];
		repeat (4) @(posedge clk);
	endtask : slv
	// master byte: mode, order, enables and collision follow the rate code
	task mxfer(input logic [2:0] r);
		logic [7:0] s, tx;
		logic col, v;
		int t;
		s = {5'h0, r[0], 1'b0, r[1]};
		tx = 8'h96 ^ {5'h0, r};
		col = (r == 3'h1 || r == 3'h6);
		peerTx <= 8'h3C ^ {r, 5'h0};
		peerCpha <= r[0];
		peerLsb <= r[0];
		wr(IDX_EV_CLR, 8'h07);
		wr(IDX_EV_EN, {5'h0, r[2], 2'b00});
		wr(IDX_SPI_STAT, s);
		wr(IDX_SPI_CTRL, {3'b101, r[1:0], r});
		// a new idle level lands now; keep it apart from the peer's frame start
		@(posedge clk);
		restart <= 1'b1;
		@(posedge clk);
		restart <= 1'b0;
		chk("idle", 32'(sckOut), 32'(r[1]));
		wr(IDX_SPI_DATA, tx);
		if (col)
			wr(IDX_SPI_DATA, 8'hFF);
		t = 0;
		v = sckOut;
		while (sckOut === v && t < 600)
		begin
			@(posedge clk);
			t++;
		end
		v = sckOut;
		t = 0;
		while (sckOut === v && t < 600)
		begin
			@(posedge clk);
			t++;
		end
		chk("half", 32'(t), 32'(2 << r));
		t = 0;
		do
		begin
			rd(IDX_SPI_STAT, q);
			t++;
		end
		while (q[7] !== 1'b1 && t < 3000);
		chk("status", q & 32'hCD, {24'h0, 1'b1, col, 2'b00, 1'b1, s[2], 1'b0, s[0]});
		chk("irq", 32'(irq), 32'(r[1] | r[2]));
		rd(IDX_EV_STAT, q);
		chk("events", q, {29'h0, 1'b1, col, 1'b1});
		rd(IDX_SPI_DATA, q);
		chk("rx", q, {24'h0, 8'h3C ^ {r, 5'h0}});
		chk("peer", 32'(peerRx), 32'(tx));
		wr(IDX_SPI_STAT, s);
		wr(IDX_EV_CLR, 8'h07);
		rd(IDX_SPI_STAT, q);
		chk("cleared", q & 32'hC8, 0);
		chk("irq off", 32'(irq), 0);
		chk("rest", 32'(sckOut), 32'(r[1]));
	endtask : mxfer
	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial
	begin
		// all rates together need about 9000 clocks; leave ample margin
		#400000;
		errors++;
		stop_test;
	end
	initial
	begin
		{rst, read, write, tSck, tMosi, restart, peerCpha, peerLsb} = 8'h80;
		{ssN, address, writedata, byteenable, peerTx} = {1'b1, 10'h0, 32'h0, 4'hF, 8'h0};
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd(IDX_SPI_CTRL, q);
		chk("ctrl reset", q, 0);
		rd(8'h10, q);
		chk("unmapped", q, 0);
		wr(IDX_OUT_CTRL, 8'h40);
		for (int r = 0; r < 8; r++)
			mxfer(3'(r));
		wr(IDX_SPI_CTRL, 8'h80);
		wr(IDX_SPI_STAT, 8'h00);
		slv(1'b1, 8'hC6, b);
		chk("slave tx", 32'(b), 0);
		rd(IDX_SPI_DATA, q);
		chk("slave rx", q, 32'hC6);
		chk("float", 32'(misoOe), 0);
		slv(1'b1, 8'h3B, b);
		rd(IDX_SPI_DATA, q);
		chk("held", q, 32'hC6);
		wr(IDX_SPI_STAT, 8'h00);
		slv(1'b0, 8'h77, b);
		rd(IDX_SPI_STAT, q);
		chk("unselected", q & 32'h80, 0);
		wr(IDX_SPI_DATA, 8'h5E);
		slv(1'b1, 8'h11, b);
		chk("slave load", 32'(b), 32'h5E);
		wr(IDX_SPI_STAT, 8'h00);
		wr(IDX_OUT_CTRL, 8'h00);
		wr(IDX_SPI_CTRL, 8'hA0);
		wr(IDX_SPI_DATA, 8'h55);
		repeat (40) @(posedge clk);
		chk("off oe", 32'(sckOe), 0);
		rd(IDX_SPI_STAT, q);
		chk("off flags", q & 32'hC8, 0);
		for (int p = 0; p < 4; p++)
		begin
			wr(IDX_OUT_CTRL, 8'(p << 6));
			chk("twi", 32'(twiEnable), 32'(p == 2));
			chk("uart", 32'(uartEnable), 32'(p == 3));
		end
		stop_test;
	end
endmodule : test_ssp_core
